// file: verilog/art_map.vh
// Register map, field positions and constants of the auto-reload capture timer
`ifndef ART_MAP_VH
`define ART_MAP_VH

// Byte addresses on the Wishbone bus
`define ART_ADR_CTRL 8'h00
`define ART_ADR_CNTL 8'h04
`define ART_ADR_CNTH 8'h08
`define ART_ADR_RLDL 8'h0C
`define ART_ADR_RLDH 8'h10
`define ART_ADR_CKEN 8'h14

// Timer control register fields
`define ART_B_HFLAG 7
`define ART_B_LFLAG 6
`define ART_B_LIEN 5
`define ART_B_CAPEN 4
`define ART_B_SPLIT 3
`define ART_B_RUN 2
`define ART_B_SRC1 1
`define ART_B_SRC0 0

// Clock select and interrupt enable register fields
`define ART_B_LSEL 0
`define ART_B_HSEL 1
`define ART_B_IEN 2

// Clock source field codes
`define ART_SRC_EXT 2'h1
`define ART_SRC_CMP 2'h3

// Reset values
`define ART_RST_BYTE 8'h00
`define ART_RST_WORD 32'h00000000

// Byte and word limits
`define ART_BYTE_MAX 8'hFF
`define ART_WORD_MAX 16'hFFFF

// Prescalers
`define ART_DIV_SYS 4'hB
`define ART_DIV_EXT 3'h7

`endif

// file: verilog/art_timer.v
// Auto-reload capture timer with a classic Wishbone register slave
//
// Contract
// - Split clear: one 16-bit auto-reload counter
// - 16-bit clocks: system_clock, /12, ext/8, comparator
// - Ext/8 and comparator synchronised to clock
// - 16-bit wrap loads reload outside capture mode (wraps to zero there), sets high flag
// - 16-bit overflow requests interrupt when enabled
// - Low byte wrap interrupts when low enabled
// - Split: two 8-bit counters, own reloads
// - Split: run gates high half only
// - Per-half select: system_clock or source field
// - Split: each half wrap sets its flag
// - Split interrupts: high, plus low if enabled
// - Flags cleared only by software writes
// - Capture enable bit selects capture mode
// - Capture on comparator rise or ext/8
// - Select 1, source bit1 0: system_clock count
// - Capture copies count, sets high flag
// - Low wrap sets low flag in every mode
`timescale 1ns/1ns
`include "art_map.vh"

module art_timer (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output wire [31:0] dat_o,
   output wire ack_o,
   input wire ext_osc_i,
   input wire cmp_i,
   output wire irq_o
);

////////////////////////////////////////////////////////////////////////////////

reg [7:0] ctrl_ff;
reg [7:0] nxt_ctrl;
reg [2:0] cken_ff;
reg [2:0] nxt_cken;
reg [7:0] cntl_ff;
reg [7:0] nxt_cntl;
reg [7:0] cnth_ff;
reg [7:0] nxt_cnth;
reg [7:0] rldl_ff;
reg [7:0] nxt_rldl;
reg [7:0] rldh_ff;
reg [7:0] nxt_rldh;
reg ack_ff;
reg [7:0] rdat_ff;
reg [7:0] nxt_rdat;

// Synchronisers, then edge history read only from the second stage
reg ext_s1_ff;
reg ext_s2_ff;
reg ext_s3_ff;
reg cmp_s1_ff;
reg cmp_s2_ff;
reg cmp_s3_ff;
reg [2:0] ext_div_ff;
reg [3:0] sys_div_ff;

wire req;
wire wr;
wire wr_ctrl;
wire wr_cntl;
wire wr_cnth;
wire wr_rldl;
wire wr_rldh;
wire wr_cken;
wire rd_load;
wire nxt_ack;
wire cap_evt;
wire high_irq;
wire low_irq;
wire ext_rise;
wire ext8_pulse;
wire cmp_rise;
wire sys12_pulse;
reg tick_l;
reg tick_h;
wire trig;
wire split;
wire run;
wire capen;
wire low_wrap;
wire high_wrap;
wire [15:0] cnt16;
wire [15:0] cnt16_inc;
reg set_h;
reg set_l;

////////////////////////////////////////////////////////////////////////////////

assign req = cyc_i & stb_i;
// Writes land on the edge where the master sees ack
assign wr = req & we_i & ack_ff & sel_i[0];
assign wr_ctrl = wr & (adr_i == `ART_ADR_CTRL);
// Decoded write strobes, one per register
assign wr_cntl = wr & (adr_i == `ART_ADR_CNTL);
assign wr_cnth = wr & (adr_i == `ART_ADR_CNTH);
assign wr_rldl = wr & (adr_i == `ART_ADR_RLDL);
assign wr_rldh = wr & (adr_i == `ART_ADR_RLDH);
assign wr_cken = wr & (adr_i == `ART_ADR_CKEN);
// Read data loads only at request start, so it stands until the next access
assign rd_load = req & ~ack_ff;
assign nxt_ack = rd_load;
assign ack_o = ack_ff;
assign dat_o = {24'h000000, rdat_ff};

assign split = ctrl_ff[`ART_B_SPLIT];
assign run = ctrl_ff[`ART_B_RUN];
assign capen = ctrl_ff[`ART_B_CAPEN];
assign cnt16 = {cnth_ff, cntl_ff};
assign cnt16_inc = cnt16 + 16'h0001;

assign ext_rise = ext_s2_ff & ~ext_s3_ff;
assign cmp_rise = cmp_s2_ff & ~cmp_s3_ff;
assign ext8_pulse = ext_rise & (ext_div_ff == `ART_DIV_EXT);
assign sys12_pulse = (sys_div_ff == `ART_DIV_SYS);

always @(posedge clk_i) begin
   if (rst_i) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      ext_div_ff <= 3'h0;
      sys_div_ff <= 4'h0;
   end else begin
      ext_s1_ff <= ext_osc_i;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      cmp_s1_ff <= cmp_i;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      if (ext_rise) begin
         ext_div_ff <= ext_div_ff + 3'h1;
      end
      if (sys12_pulse) begin
         sys_div_ff <= 4'h0;
      end else begin
         sys_div_ff <= sys_div_ff + 4'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////

always @* begin
   case (ctrl_ff[`ART_B_SRC1:`ART_B_SRC0])
      `ART_SRC_EXT: tick_l = ext8_pulse;
      `ART_SRC_CMP: tick_l = cmp_rise;
      default: tick_l = sys12_pulse;
   endcase
   tick_h = tick_l;
   if (cken_ff[`ART_B_LSEL]) begin
      tick_l = 1'b1;
   end
   if (cken_ff[`ART_B_HSEL]) begin
      tick_h = 1'b1;
   end
end

// source bit 1 clear: comparator trigger
assign trig = ctrl_ff[`ART_B_SRC1] ? ext8_pulse : cmp_rise;
assign cap_evt = capen & run & trig;

// 16-bit advance needs run and low-half tick
// split: low free running, high gated by run
assign low_wrap = (split ? tick_l : (run & tick_l)) & (cntl_ff == `ART_BYTE_MAX);
assign high_wrap = split ? (run & tick_h & (cnth_ff == `ART_BYTE_MAX))
                         : (run & tick_l & (cnt16 == `ART_WORD_MAX));

always @* begin
   nxt_cntl = cntl_ff;
   nxt_cnth = cnth_ff;
   nxt_rldl = rldl_ff;
   nxt_rldh = rldh_ff;
   set_h = 1'b0;
   set_l = 1'b0;
   if (split) begin
      if (tick_l) begin
         nxt_cntl = low_wrap ? rldl_ff : cntl_ff + 8'h01;
      end
      if (run & tick_h) begin
         nxt_cnth = high_wrap ? rldh_ff : cnth_ff + 8'h01;
      end
      set_h = high_wrap;
      set_l = low_wrap;
   end else if (run & tick_l) begin
      // 16-bit count, reload on wrap
      // Capture mode wraps to zero since reload holds captures
      if (high_wrap & ~capen) begin
         {nxt_cnth, nxt_cntl} = {rldh_ff, rldl_ff};
      end else begin
         {nxt_cnth, nxt_cntl} = cnt16_inc;
      end
      set_h = high_wrap;
      // low wrap flagged in 16-bit mode too
      set_l = low_wrap;
   end
   // Software writes to the count win over counting
   if (wr_cntl) begin
      nxt_cntl = dat_i[7:0];
   end
   if (wr_cnth) begin
      nxt_cnth = dat_i[7:0];
   end
   if (wr_rldl) begin
      nxt_rldl = dat_i[7:0];
   end
   if (wr_rldh) begin
      nxt_rldh = dat_i[7:0];
   end
   // capture copies count, wins over reload write
   if (cap_evt) begin
      {nxt_rldh, nxt_rldl} = cnt16;
      set_h = 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////////

// flags set by hardware or by writing 1, cleared only by writes; set wins
always @* begin
   nxt_ctrl = ctrl_ff;
   if (wr_ctrl) begin
      nxt_ctrl = dat_i[7:0];
   end
   if (set_h) begin
      nxt_ctrl[`ART_B_HFLAG] = 1'b1;
   end
   if (set_l) begin
      nxt_ctrl[`ART_B_LFLAG] = 1'b1;
   end
end

// interrupt request from flags and enables
assign high_irq = ctrl_ff[`ART_B_HFLAG];
assign low_irq = ctrl_ff[`ART_B_LIEN] & ctrl_ff[`ART_B_LFLAG];
assign irq_o = cken_ff[`ART_B_IEN] & (high_irq | low_irq);

// Clock select and interrupt enable register
always @* begin
   nxt_cken = cken_ff;
   if (wr_cken) begin
      nxt_cken = dat_i[2:0];
   end
end

// Read data captured in the request's first cycle; unmapped reads zero
always @* begin
   case (adr_i)
      `ART_ADR_CTRL: nxt_rdat = ctrl_ff;
      `ART_ADR_CNTL: nxt_rdat = cntl_ff;
      `ART_ADR_CNTH: nxt_rdat = cnth_ff;
      `ART_ADR_RLDL: nxt_rdat = rldl_ff;
      `ART_ADR_RLDH: nxt_rdat = rldh_ff;
      `ART_ADR_CKEN: nxt_rdat = {5'h00, cken_ff};
      default: nxt_rdat = `ART_RST_BYTE;
   endcase
end

always @(posedge clk_i) begin
   if (rst_i) begin
      ctrl_ff <= `ART_RST_BYTE;
      cken_ff <= 3'h0;
      cntl_ff <= `ART_RST_BYTE;
      cnth_ff <= `ART_RST_BYTE;
      rldl_ff <= `ART_RST_BYTE;
      rldh_ff <= `ART_RST_BYTE;
      ack_ff <= 1'b0;
      rdat_ff <= `ART_RST_BYTE;
   end else begin
      ctrl_ff <= nxt_ctrl;
      cntl_ff <= nxt_cntl;
      cnth_ff <= nxt_cnth;
      rldl_ff <= nxt_rldl;
      rldh_ff <= nxt_rldh;
      ack_ff <= nxt_ack;
      if (rd_load) begin
         rdat_ff <= nxt_rdat;
      end
      cken_ff <= nxt_cken;
   end
end

endmodule // art_timer

// file: test/art_timer_assertions.sv
// Port checker for the auto-reload capture timer
`timescale 1ns/1ns
module art_chk (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [7:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire ext_osc_i,
   input wire cmp_i,
   input wire irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
a_upper_zero: assert property (dat_o[31:8] == 24'h000000) else $error("upper data set");
a_unmapped_zero: assert property (ack_o && !we_i && adr_i > 8'h14 |-> dat_o == 32'h00000000)
   else $error("unmapped read not zero");
a_dat_held: assert property (!(cyc_i && stb_i) |=> $stable(dat_o)) else $error("data moved");
// Flags only fall by a software write
a_irq_sticky: assert property ($fell(irq_o) |-> $past(ack_o && we_i)) else $error("irq fell");
a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o && dat_o == 0)
   else $error("reset outputs");
endmodule // art_chk
////////////////////////////////////////////////////////////////////////////////
bind art_timer art_chk u_art_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .ext_osc_i(ext_osc_i), .cmp_i(cmp_i), .irq_o(irq_o));

// file: test/test_auto_reload_capture_timer.sv
// Self-checking bench for the auto-reload capture timer
`timescale 1ns/1ns
module test_auto_reload_capture_timer;
reg clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_osc_i = 0, cmp_i = 0;
reg [7:0] adr_i = 8'h00;
reg [3:0] sel_i = 4'hF;
reg [31:0] dat_i = 32'h00000000;
wire [31:0] dat_o;
wire ack_o, irq_o;
integer bad_count = 0, samples_checked = 0;
reg [7:0] v;
art_timer u_art_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .ext_osc_i(ext_osc_i), .cmp_i(cmp_i), .irq_o(irq_o));
initial forever #20 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////////////////////
task chk(input [7:0] got, input [7:0] exp); begin
   samples_checked = samples_checked + 1;
   if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
   end
end endtask
// One classic cycle; waits for ack whatever the latency
task bus(input w, input [7:0] a, input [7:0] d); begin
   @(posedge clk_i);
   cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h000000, d};
   @(posedge clk_i);
   while (ack_o !== 1'b1) @(posedge clk_i);
   v = dat_o[7:0];
   cyc_i <= 0; stb_i <= 0; we_i <= 0;
end endtask
task wr(input [7:0] a, input [7:0] d); bus(1, a, d); endtask
task rc(input [7:0] a, input [7:0] e); begin bus(0, a, 8'h00); chk(v, e); end endtask
// Pin levels last two clocks high and three low so the synchroniser cannot miss an edge
task pulse(input c, input integer n); integer i; begin
   for (i = 0; i < n; i = i + 1) begin
      @(posedge clk_i); if (c) cmp_i <= 1; else ext_osc_i <= 1;
      repeat (2) @(posedge clk_i); if (c) cmp_i <= 0; else ext_osc_i <= 0;
      repeat (2) @(posedge clk_i);
   end
end endtask
////////////////////////////////////////////////////////////////////////////////
task t_regs; integer a; begin
   for (a = 0; a < 8'h18; a = a + 4) rc(a[7:0], 8'h00);
   wr(8'h0C, 8'hA5); rc(8'h0C, 8'hA5);
   wr(8'h18, 8'h55); rc(8'h18, 8'h00);
   $display("regs done");
end endtask
task t_sources; begin
   wr(8'h14, 8'h00); wr(8'h04, 8'h00); wr(8'h00, 8'h05);
   pulse(0, 16); rc(8'h04, 8'h02);
   wr(8'h04, 8'h00); wr(8'h00, 8'h07);
   pulse(1, 5); rc(8'h04, 8'h05);
   wr(8'h04, 8'h00); wr(8'h00, 8'h04);
   repeat (119) @(posedge clk_i);
   wr(8'h00, 8'h00); bus(0, 8'h04, 8'h00);
   chk({7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
   $display("sources done");
end endtask
task t_wrap16; begin
   wr(8'h14, 8'h05); wr(8'h0C, 8'h34); wr(8'h10, 8'h12);
   wr(8'h08, 8'hFF); wr(8'h04, 8'hFD); wr(8'h00, 8'h04);
   repeat (20) @(posedge clk_i);
   rc(8'h08, 8'h12);
   rc(8'h00, 8'hC4);
   chk({7'h00, irq_o}, 8'h01);
   wr(8'h00, 8'h00); wr(8'h04, 8'h50);
   chk({7'h00, irq_o}, 8'h00);
   repeat (5) @(posedge clk_i);
   rc(8'h04, 8'h50);
   $display("wrap16 done");
end endtask
task t_split; begin
   wr(8'h14, 8'h07); wr(8'h0C, 8'hF0); wr(8'h10, 8'h33);
   wr(8'h08, 8'h44); wr(8'h04, 8'hFE); wr(8'h00, 8'h08);
   repeat (4) @(posedge clk_i);
   rc(8'h08, 8'h44);
   rc(8'h00, 8'h48);
   chk({7'h00, irq_o}, 8'h00);
   wr(8'h00, 8'h68); @(posedge clk_i);
   chk({7'h00, irq_o}, 8'h01);
   wr(8'h08, 8'hFE); wr(8'h00, 8'h0C);
   repeat (4) @(posedge clk_i);
   bus(0, 8'h00, 8'h00); chk(v & 8'h80, 8'h80);
   wr(8'h00, 8'h00);
   $display("split done");
end endtask
task t_capture; begin
   wr(8'h14, 8'h05); wr(8'h0C, 8'h00); wr(8'h10, 8'h00);
   wr(8'h08, 8'h10); wr(8'h04, 8'h00); wr(8'h00, 8'h14);
   pulse(1, 1);
   bus(0, 8'h00, 8'h00); chk(v & 8'h80, 8'h80);
   wr(8'h00, 8'h00);
   rc(8'h10, 8'h10);
   wr(8'h00, 8'h16);
   pulse(0, 8);
   bus(0, 8'h00, 8'h00); chk(v & 8'h80, 8'h80);
   wr(8'h00, 8'h00);
   $display("capture done");
end endtask
task finish_test; begin
   $display("checked %0d bad %0d", samples_checked, bad_count);
   if (bad_count == 0 && samples_checked > 0) $display("bench passed");
   else $display("bench failed");
   $finish;
end endtask
initial begin
   #(40 * 8000);
   bad_count = bad_count + 1;
   finish_test;
end
initial begin
   repeat (4) @(posedge clk_i);
   rst_i <= 0;
   t_regs;
   t_sources;
   t_wrap16;
   t_split;
   t_capture;
   finish_test;
end
endmodule // test_auto_reload_capture_timer
